// ---- logic/gate_drive_init_sequencer.v ----
// host-side sequencer that brings a three phase gate predriver out of reset
`timescale 1ns/1ps
`default_nettype none
`include "init_seq_defs.vh"
// Function
// - low-side first rise 280 ns after permits, rounded up to 300 ns
// - reset, configure, clear, then raise permits
// - initial low pulse 1.0 us, 100 ns recovery
// - high-side on pulse dead time plus 100 ns
// - zero gap low pulse end to high pulse
// - permits may rise right after configuration
// - normal operation right after high-side off
// - wait 2.0 ms after reset release
// - toggle all phases together
module gate_drive_init_sequencer #(
  parameter SETTLE_NS = `SETTLE_TIME_NS,
  parameter DEAD_NS = `DEAD_TIME_NS
) (
  // clock and reset
  input wire mclk_in,
  input wire rst_in,
  // user control
  input wire start_in,
  input wire recovery_in,
  input wire config_done_in,
  input wire [2:0] user_low_in,
  input wire [2:0] user_high_n_in,
  output wire config_req_out,
  output wire ready_out,
  output wire busy_out,
  // device pins
  output reg device_reset_n_out,
  output reg drive_permit_a_pin_out,
  output reg drive_permit_b_pin_out,
  output reg [2:0] phase_low_cmd_out,
  output reg [2:0] phase_high_cmd_n_out
);
  // rounds up so no interval falls short of its minimum, at the cost of up to one cycle
  function integer cyc_min;
    input integer ns;
    begin
      cyc_min = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
      if (cyc_min < 1)
        cyc_min = 1;
    end
  endfunction

  localparam integer SETTLE_CYC = cyc_min(SETTLE_NS);
  localparam integer PERMIT_CYC = cyc_min(`PERMIT_TO_LOW_NS);
  localparam integer LOW_FULL_CYC = cyc_min(`LOW_PULSE_FULL_NS);
  localparam integer LOW_REC_CYC = cyc_min(`LOW_PULSE_RECOVER_NS);
  localparam integer HIGH_CYC = cyc_min(DEAD_NS + `HIGH_MARGIN_NS);
  localparam integer CW = `CNT_W;

  // loads cut to the counter width on purpose; the width covers far more than the settle wait
  localparam [CW-1:0] SETTLE_LD = SETTLE_CYC[CW-1:0];
  localparam [CW-1:0] PERMIT_LD = PERMIT_CYC[CW-1:0];
  localparam [CW-1:0] LOW_FULL_LD = LOW_FULL_CYC[CW-1:0];
  localparam [CW-1:0] LOW_REC_LD = LOW_REC_CYC[CW-1:0];
  localparam [CW-1:0] HIGH_LD = HIGH_CYC[CW-1:0];

  // counts end at one, so a load of one lasts a single cycle
  function count_done;
    input [CW-1:0] cnt;
    begin
      count_done = (cnt <= `CNT_LAST);
    end
  endfunction

  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_SETTLE = 8'h02;
  localparam [7:0] S_CONFIG = 8'h04;
  localparam [7:0] S_PERMIT = 8'h08;
  localparam [7:0] S_LOW = 8'h10;
  localparam [7:0] S_HIGH = 8'h20;
  localparam [7:0] S_RUN = 8'h40;
  localparam [7:0] S_PRE = 8'h80;

  reg [7:0] state_q;
  reg [CW-1:0] cnt_q;
  reg recov_q;

  // a recovery start only counts when the device is already out of reset
  wire warm_start;
  assign warm_start = recovery_in & device_reset_n_out;

  assign config_req_out = (state_q == S_CONFIG);
  assign ready_out = (state_q == S_RUN);
  assign busy_out = (state_q != S_IDLE) && (state_q != S_RUN);

  always @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state_q <= S_IDLE;
      cnt_q <= {CW{1'b0}};
      recov_q <= 1'b0;
      device_reset_n_out <= 1'b0;
      drive_permit_a_pin_out <= 1'b0;
      drive_permit_b_pin_out <= 1'b0;
      phase_low_cmd_out <= `ALL_OFF;
      phase_high_cmd_n_out <= `ALL_ON;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          // permits stay low across reset release
          drive_permit_a_pin_out <= 1'b0;
          drive_permit_b_pin_out <= 1'b0;
          phase_low_cmd_out <= `ALL_OFF;
          phase_high_cmd_n_out <= `ALL_ON;
          if (start_in)
          begin
            recov_q <= warm_start;
            device_reset_n_out <= 1'b1;
            cnt_q <= SETTLE_LD;
            // a device that was just held in reset always gets the full settle wait
            state_q <= warm_start ? S_CONFIG : S_SETTLE;
          end
        end
        S_SETTLE:
        begin
          // settle counts from the edge that releases the device reset
          if (count_done(cnt_q))
            state_q <= S_CONFIG;
          cnt_q <= cnt_q - 1'b1;
        end
        S_CONFIG:
        begin
          // configuration and interrupt clear happen outside, over spi
          if (config_done_in)
          begin
            drive_permit_a_pin_out <= 1'b1;
            drive_permit_b_pin_out <= 1'b1;
            cnt_q <= PERMIT_LD;
            state_q <= S_PERMIT;
          end
        end
        S_PERMIT:
        begin
          if (count_done(cnt_q))
          begin
            // all phases together keeps the motor still
            phase_low_cmd_out <= `ALL_ON;
            cnt_q <= recov_q ? LOW_REC_LD : LOW_FULL_LD;
            state_q <= S_LOW;
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        S_LOW:
        begin
          if (count_done(cnt_q))
          begin
            // high edge follows low toggle with no gap
            phase_low_cmd_out <= `ALL_OFF;
            phase_high_cmd_n_out <= `ALL_OFF;
            cnt_q <= HIGH_LD;
            state_q <= S_HIGH;
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        S_HIGH:
        begin
          // dead time plus margin before the high side goes off again
          if (count_done(cnt_q))
          begin
            phase_high_cmd_n_out <= `ALL_ON;
            state_q <= S_RUN;
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        S_RUN:
        begin
          // user commands pass straight through once initialised
          phase_low_cmd_out <= user_low_in;
          phase_high_cmd_n_out <= user_high_n_in;
          // a new start parks the phases at safe levels before reinitialising
          if (start_in)
          begin
            phase_low_cmd_out <= `ALL_OFF;
            phase_high_cmd_n_out <= `ALL_ON;
            state_q <= S_PRE;
          end
        end
        S_PRE:
        begin
          // one cycle that drops the permits, then back to idle to wait for the next start
          drive_permit_a_pin_out <= 1'b0;
          drive_permit_b_pin_out <= 1'b0;
          // recovery keeps the device out of reset, so the settle wait can be skipped
          device_reset_n_out <= recovery_in;
          state_q <= S_IDLE;
        end
        default:
        begin
          // an upset state parks the pins safe before starting over
          drive_permit_a_pin_out <= 1'b0;
          drive_permit_b_pin_out <= 1'b0;
          phase_low_cmd_out <= `ALL_OFF;
          phase_high_cmd_n_out <= `ALL_ON;
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- logic/init_seq_defs.vh ----
// timing and encoding constants for the gate drive init sequencer
`ifndef INIT_SEQ_DEFS_VH
`define INIT_SEQ_DEFS_VH
`define CLK_PERIOD_NS 100
`define SETTLE_TIME_NS 2000000
`define PERMIT_TO_LOW_NS 280
`define LOW_PULSE_FULL_NS 1000
`define LOW_PULSE_RECOVER_NS 100
`define HIGH_MARGIN_NS 100
`define DEAD_TIME_NS 0
`define CNT_W 24
`define CNT_LAST 1
`define PHASES 3
`define ALL_ON 3'h7
`define ALL_OFF 3'h0
`endif

// ---- tb/init_seq_asserts.sv ----
// port assertions for the gate drive init sequencer
`timescale 1ns/1ps
`default_nettype none
module init_seq_checker (
  input wire mclk_in, rst_in, recovery_in, config_done_in, config_req_out, ready_out, busy_out,
  input wire device_reset_n_out, drive_permit_a_pin_out, drive_permit_b_pin_out,
  input wire [2:0] phase_low_cmd_out, phase_high_cmd_n_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  wire [2:0] lo = phase_low_cmd_out;
  wire [2:0] hi = phase_high_cmd_n_out;
  wire pa = drive_permit_a_pin_out;
  permit_gap_a: assert property ($rose(pa) |-> lo == 3'h0 [*3] ##1 lo == 3'h7) else $error("low gap");
  low_pulse_a: assert property ($rose(lo[0]) && busy_out && !recovery_in |-> ##9 lo == 3'h7 ##1 lo == 3'h0)
    else $error("low pulse");
  low_high_a: assert property ($fell(lo[0]) && $past(busy_out) |-> hi == 3'h0) else $error("high late");
  high_pulse_a: assert property ($fell(hi[0]) && busy_out |-> hi == 3'h0 ##1 hi == 3'h7) else $error("high");
  ready_after_a: assert property ($rose(ready_out) |-> hi == 3'h7 && $past(hi) == 3'h0) else $error("ready");
  permit_pair_a: assert property (pa == drive_permit_b_pin_out) else $error("permits");
  cfg_permit_a: assert property (config_req_out && config_done_in |=> pa) else $error("permit late");
  cfg_order_a: assert property (config_req_out |-> device_reset_n_out && !pa) else $error("order");
  cover property ($rose(ready_out));
  cover property ($rose(lo[0]) && recovery_in);
  cover property (config_req_out && config_done_in);
endmodule
bind gate_drive_init_sequencer init_seq_checker chk (.mclk_in, .rst_in, .recovery_in, .config_done_in,
  .config_req_out, .ready_out, .busy_out, .device_reset_n_out, .drive_permit_a_pin_out,
  .drive_permit_b_pin_out, .phase_low_cmd_out, .phase_high_cmd_n_out);
`default_nettype wire

// ---- tb/predriver_model.sv ----
// behavioural model of the predriver input logic
`timescale 1ns/1ps
`default_nettype none
module predriver_model (
  input wire logic clk_in, rst_n_in, en_a_in, en_b_in,
  input wire logic [2:0] low_in, high_n_in,
  output logic [2:0] held_out
);
  logic [2:0] low_p_q, armed_q, seen_q, held_q;
  assign held_out = held_q;
  always_ff @(posedge clk_in)
  begin
    low_p_q <= low_in;
    if (!rst_n_in)
    begin
      armed_q <= 3'h0;
      seen_q <= 3'h0;
      held_q <= 3'h0;
    end
    else if (en_a_in && en_b_in)
    begin
      armed_q <= armed_q | (low_in & ~low_p_q);
      seen_q <= seen_q | (armed_q & ~low_in & ~high_n_in);
      held_q <= held_q | (seen_q & high_n_in);
    end
    else
    begin
      // permits low park the device, so the high side must be set up again
      armed_q <= 3'h0;
      seen_q <= 3'h0;
      held_q <= 3'h0;
    end
  end
endmodule
`default_nettype wire

// ---- tb/gate_drive_init_sequencer_tb.sv ----
// self-checking bench for the gate drive init sequencer
`timescale 1ns/1ps
`default_nettype none
module gate_drive_init_sequencer_tb;
  logic mclk_in = 0, rst_in = 1, start_in = 0, recovery_in = 0, config_done_in = 0;
  logic [2:0] user_low_in = 3'h0, user_high_n_in = 3'h7;
  wire config_req_out, ready_out, busy_out, device_reset_n_out, drive_permit_a_pin_out, drive_permit_b_pin_out;
  wire [2:0] phase_low_cmd_out, phase_high_cmd_n_out, held;
  int fails = 0, check_count = 0;
  gate_drive_init_sequencer #(.SETTLE_NS(1000)) dut (.mclk_in, .rst_in, .start_in, .recovery_in, .config_done_in,
    .user_low_in, .user_high_n_in, .config_req_out, .ready_out, .busy_out, .device_reset_n_out,
    .drive_permit_a_pin_out, .drive_permit_b_pin_out, .phase_low_cmd_out, .phase_high_cmd_n_out);
  predriver_model dev (.clk_in(mclk_in), .rst_n_in(device_reset_n_out), .en_a_in(drive_permit_a_pin_out),
    .en_b_in(drive_permit_b_pin_out), .low_in(phase_low_cmd_out), .high_n_in(phase_high_cmd_n_out), .held_out(held));
  initial forever #50 mclk_in = ~mclk_in;
  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // early config_done must be ignored; pulse width counted at the pins
  task bring_up(input logic rec, input logic [7:0] want_low);
    int i, n;
    n = 0;
    start_in <= 1;
    recovery_in <= rec;
    tick(1);
    start_in <= 0;
    config_done_in <= !rec;
    tick(2);
    config_done_in <= 0;
    check({device_reset_n_out, drive_permit_a_pin_out}, 8'h02);
    for (i = 0; i < 100 && config_req_out !== 1'b1; i++) tick(1);
    // settle is ten cycles from the start edge and this wait begins two edges in
    check(i, rec ? 8'h00 : 8'h08);
    config_done_in <= 1;
    tick(1);
    config_done_in <= 0;
    for (i = 0; i < 60 && ready_out !== 1'b1; i++)
    begin
      tick(1);
      if (phase_low_cmd_out === 3'h7) n++;
    end
    check(n, want_low);
    // the device latches its high side one edge after the high-off command
    tick(1);
    check({ready_out, busy_out, held}, 8'h17);
  endtask
  initial
  begin
    tick(12);
    check({device_reset_n_out, drive_permit_a_pin_out, phase_low_cmd_out, phase_high_cmd_n_out}, 8'h07);
    rst_in <= 0;
    bring_up(0, 8'h0A);
    user_low_in <= 3'h1;
    user_high_n_in <= 3'h5;
    tick(3);
    check({phase_low_cmd_out, phase_high_cmd_n_out}, 8'h0D);
    user_low_in <= 3'h0;
    user_high_n_in <= 3'h7;
    start_in <= 1;
    recovery_in <= 1;
    tick(1);
    start_in <= 0;
    tick(4);
    check({ready_out, device_reset_n_out, drive_permit_a_pin_out}, 8'h02);
    bring_up(1, 8'h01);
    report_and_stop();
  end
  initial
  begin
    #400000;
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
